// ### core/cond_check.sv
// Evaluates a condition code against the current flags
`timescale 1ns/1ps
`default_nettype none
module cond_check (
   input  wire logic [3:0] cond,
   input  wire logic [3:0] flags,
   output logic            pass
);
   logic n;
   logic z;
   logic c;
   logic v;

   always_comb begin
      n = flags[simd_pack_pkg::FLAG_N];
      z = flags[simd_pack_pkg::FLAG_Z];
      c = flags[simd_pack_pkg::FLAG_C];
      v = flags[simd_pack_pkg::FLAG_V];
      case (cond)
         simd_pack_pkg::COND_EQ: pass = z;
         simd_pack_pkg::COND_NE: pass = !z;
         simd_pack_pkg::COND_CS: pass = c;
         simd_pack_pkg::COND_CC: pass = !c;
         simd_pack_pkg::COND_MI: pass = n;
         simd_pack_pkg::COND_PL: pass = !n;
         simd_pack_pkg::COND_VS: pass = v;
         simd_pack_pkg::COND_VC: pass = !v;
         simd_pack_pkg::COND_HI: pass = c && !z;
         simd_pack_pkg::COND_LS: pass = !c || z;
         simd_pack_pkg::COND_GE: pass = (n == v);
         simd_pack_pkg::COND_LT: pass = (n != v);
         simd_pack_pkg::COND_GT: pass = !z && (n == v);
         simd_pack_pkg::COND_LE: pass = z || (n != v);
         default:                pass = 1'b1;
      endcase
   end
endmodule
`default_nettype wire

// ### core/simd_pack_alu.sv
// Execute-stage datapath for unsigned saturating SIMD, halfword pack and extend operations
// Timing
// One operation may be taken on every clock and is answered on the next one.
// The result and its destination hold until an operation whose predicate passes.
// A failed predicate or a spare code leaves the result and its destination as they were.
`timescale 1ns/1ps
`default_nettype none
module simd_pack_alu #(
   parameter int W = simd_pack_pkg::WORD_W
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         issueValid,
   input  wire logic [3:0]   opcode,
   input  wire logic [3:0]   cond,
   input  wire logic [3:0]   flagsIn,
   input  wire logic [W-1:0] operandA,
   input  wire logic [W-1:0] operandB,
   input  wire logic [4:0]   shiftAmt,
   input  wire logic [1:0]   rotSel,
   input  wire logic [3:0]   destIdx,
   output logic      [W-1:0] result,
   output logic      [3:0]   resultDest,
   output logic              writeEnable,
   output logic              condFailed,
   output logic      [3:0]   flagsOut
);
   localparam int HW = simd_pack_pkg::HALF_W;
   localparam int BW = simd_pack_pkg::BYTE_W;
   localparam int NB = W / BW;

   logic [W-1:0]  addByte;
   logic [W-1:0]  subByte;
   logic [HW-1:0] aHi;
   logic [HW-1:0] aLo;
   logic [HW-1:0] bHi;
   logic [HW-1:0] bLo;
   logic [HW-1:0] addHiHi;
   logic [HW-1:0] addLoLo;
   logic [HW-1:0] subHiHi;
   logic [HW-1:0] subLoLo;
   logic [HW-1:0] asxTop;
   logic [HW-1:0] asxBot;
   logic [HW-1:0] saxTop;
   logic [HW-1:0] saxBot;
   logic [W-1:0]  shlB;
   logic [W-1:0]  asrB;
   logic [W-1:0]  rotB;
   logic [W-1:0]  sextByte;
   logic [W-1:0]  zextByte;
   logic [W-1:0]  result_next;
   logic          condPass;
   logic          result_valid;
   logic          opKnown;
   logic [W-1:0]  packBt;
   logic [W-1:0]  packTb;
   logic [W-1:0]  sextHalf;
   logic [W-1:0]  zextHalf;
   logic [W-1:0]  accSext;
   logic [W-1:0]  accZext;

   assign aHi = operandA[simd_pack_pkg::HALF_HI +: HW];
   assign aLo = operandA[simd_pack_pkg::HALF_LO +: HW];
   assign bHi = operandB[simd_pack_pkg::HALF_HI +: HW];
   assign bLo = operandB[simd_pack_pkg::HALF_LO +: HW];

   // Byte lanes: each lane saturates on its own carry or borrow
   genvar i;
   generate
      for (i = 0; i < NB; i++) begin : g_byte
         logic [BW-1:0] laneA;
         logic [BW-1:0] laneB;

         assign laneA = operandA[i*BW +: BW];
         assign laneB = operandB[i*BW +: BW];

         usat_lane #(.W(BW)) u_add (
            .a   (laneA),
            .b   (laneB),
            .sub (1'b0),
            .y   (addByte[i*BW +: BW])
         );

         usat_lane #(.W(BW)) u_sub (
            .a   (laneA),
            .b   (laneB),
            .sub (1'b1),
            .y   (subByte[i*BW +: BW])
         );
      end
   endgenerate

   // Halfword lanes, straight pairings: top with top, bottom with bottom
   usat_lane #(.W(HW)) u_addHi (
      .a   (aHi),
      .b   (bHi),
      .sub (1'b0),
      .y   (addHiHi)
   );

   usat_lane #(.W(HW)) u_addLo (
      .a   (aLo),
      .b   (bLo),
      .sub (1'b0),
      .y   (addLoLo)
   );

   usat_lane #(.W(HW)) u_subHi (
      .a   (aHi),
      .b   (bHi),
      .sub (1'b1),
      .y   (subHiHi)
   );

   usat_lane #(.W(HW)) u_subLo (
      .a   (aLo),
      .b   (bLo),
      .sub (1'b1),
      .y   (subLoLo)
   );

   // Halfword lanes, exchanged pairings: each first-operand half meets the other half
   usat_lane #(.W(HW)) u_asxT (
      .a   (aHi),
      .b   (bLo),
      .sub (1'b0),
      .y   (asxTop)
   );

   usat_lane #(.W(HW)) u_asxB (
      .a   (aLo),
      .b   (bHi),
      .sub (1'b1),
      .y   (asxBot)
   );

   usat_lane #(.W(HW)) u_saxT (
      .a   (aHi),
      .b   (bLo),
      .sub (1'b1),
      .y   (saxTop)
   );

   usat_lane #(.W(HW)) u_saxB (
      .a   (aLo),
      .b   (bHi),
      .sub (1'b0),
      .y   (saxBot)
   );

   // Predicate against the flags as they stand at issue
   cond_check u_cond (
      .cond  (cond),
      .flags (flagsIn),
      .pass  (condPass)
   );

   // Left shift for bottom-top pack: a zero field leaves the operand as it is
   always_comb begin
      shlB = operandB << shiftAmt;
   end

   // Right shift for top-bottom pack: a zero field stands for a full-width shift,
   // which leaves only copies of the sign bit
   always_comb begin
      if (shiftAmt == simd_pack_pkg::SHAMT_ZERO) begin
         asrB = {W{operandB[W-1]}};
      end else begin
         asrB = $signed(operandB) >>> shiftAmt;
      end
   end

   // Halfword pack results
   assign packBt = {shlB[W-1:HW], aLo};
   assign packTb = {aHi, asrB[HW-1:0]};

   // Extend source rotated right by 0, 8, 16 or 24 before extraction
   always_comb begin
      case (rotSel)
         2'h1:    rotB = {operandB[BW-1:0], operandB[W-1:BW]};
         2'h2:    rotB = {operandB[2*BW-1:0], operandB[W-1:2*BW]};
         2'h3:    rotB = {operandB[3*BW-1:0], operandB[W-1:3*BW]};
         default: rotB = operandB;
      endcase
   end

   assign sextByte = {{(W-BW){rotB[BW-1]}}, rotB[BW-1:0]};
   assign zextByte = {{(W-BW){1'b0}}, rotB[BW-1:0]};

   // Extended byte is added to the whole first operand; the sum wraps, it never saturates
   assign accSext = operandA + sextByte;
   assign accZext = operandA + zextByte;

   // Halfword extends take the low half of the rotated source
   assign sextHalf = {{(W-HW){rotB[HW-1]}}, rotB[HW-1:0]};
   assign zextHalf = {{(W-HW){1'b0}}, rotB[HW-1:0]};

   // Spare codes fall to the first operand here but are never written back
   always_comb begin
      case (opcode)
         simd_pack_pkg::OP_UQ_ADD16:  result_next = {addHiHi, addLoLo};
         simd_pack_pkg::OP_UQ_ADD8:   result_next = addByte;
         simd_pack_pkg::OP_UQ_SUB16:  result_next = {subHiHi, subLoLo};
         simd_pack_pkg::OP_UQ_SUB8:   result_next = subByte;
         simd_pack_pkg::OP_UQ_ASX:    result_next = {asxTop, asxBot};
         simd_pack_pkg::OP_UQ_SAX:    result_next = {saxTop, saxBot};
         simd_pack_pkg::OP_PACK_BT:   result_next = packBt;
         simd_pack_pkg::OP_PACK_TB:   result_next = packTb;
         simd_pack_pkg::OP_SEXT_BACC: result_next = accSext;
         simd_pack_pkg::OP_ZEXT_BACC: result_next = accZext;
         simd_pack_pkg::OP_SEXT_HALF: result_next = sextHalf;
         simd_pack_pkg::OP_ZEXT_HALF: result_next = zextHalf;
         default:                     result_next = operandA;
      endcase
   end

   // Only the twelve defined codes are taken; spare codes give no pulse at all
   always_comb begin
      case (opcode)
         simd_pack_pkg::OP_UQ_ADD16,
         simd_pack_pkg::OP_UQ_ADD8,
         simd_pack_pkg::OP_UQ_SUB16,
         simd_pack_pkg::OP_UQ_SUB8,
         simd_pack_pkg::OP_UQ_ASX,
         simd_pack_pkg::OP_UQ_SAX,
         simd_pack_pkg::OP_PACK_BT,
         simd_pack_pkg::OP_PACK_TB,
         simd_pack_pkg::OP_SEXT_BACC,
         simd_pack_pkg::OP_ZEXT_BACC,
         simd_pack_pkg::OP_SEXT_HALF,
         simd_pack_pkg::OP_ZEXT_HALF: opKnown = 1'b1;
         default:                     opKnown = 1'b0;
      endcase
   end

   assign result_valid = issueValid && opKnown;

   // Result word is captured only when the predicate passes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         result <= simd_pack_pkg::RESULT_RESET;
      end else if (result_valid && condPass) begin
         result <= result_next;
      end
   end

   // Destination index travels with the result it belongs to
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         resultDest <= '0;
      end else if (result_valid && condPass) begin
         resultDest <= destIdx;
      end
   end

   // One-cycle pulse for each operation written back
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         writeEnable <= 1'b0;
      end else begin
         writeEnable <= result_valid && condPass;
      end
   end

   // One-cycle pulse for each operation whose predicate failed
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         condFailed <= 1'b0;
      end else begin
         condFailed <= result_valid && !condPass;
      end
   end

   // Flags pass through untouched: no operation here alters them
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flagsOut <= 4'h0;
      end else begin
         flagsOut <= flagsIn;
      end
   end
endmodule
`default_nettype wire

// ### core/simd_pack_pkg.sv
// Shared opcodes, lane widths and field constants for the saturating SIMD and pack datapath
package simd_pack_pkg;
   localparam int WORD_W   = 32;
   localparam int HALF_W   = 16;
   localparam int BYTE_W   = 8;
   localparam int SHAMT_W  = 5;
   localparam int COND_W   = 4;
   localparam int FLAGS_W  = 4;
   localparam int ROT_W    = 2;
   localparam int HALF_LO  = 0;
   localparam int HALF_HI  = 16;
   localparam logic [4:0] SHAMT_ZERO = 5'h00;
   localparam int SHIFT_FULL = 32;
   localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

   // Condition codes, encoded as in the usual four-flag scheme
   localparam logic [3:0] COND_EQ = 4'h0;
   localparam logic [3:0] COND_NE = 4'h1;
   localparam logic [3:0] COND_CS = 4'h2;
   localparam logic [3:0] COND_CC = 4'h3;
   localparam logic [3:0] COND_MI = 4'h4;
   localparam logic [3:0] COND_PL = 4'h5;
   localparam logic [3:0] COND_VS = 4'h6;
   localparam logic [3:0] COND_VC = 4'h7;
   localparam logic [3:0] COND_HI = 4'h8;
   localparam logic [3:0] COND_LS = 4'h9;
   localparam logic [3:0] COND_GE = 4'ha;
   localparam logic [3:0] COND_LT = 4'hb;
   localparam logic [3:0] COND_GT = 4'hc;
   localparam logic [3:0] COND_LE = 4'hd;
   localparam logic [3:0] COND_AL = 4'he;

   // Flag bit positions in the flags input: N Z C V
   localparam int FLAG_N = 3;
   localparam int FLAG_Z = 2;
   localparam int FLAG_C = 1;
   localparam int FLAG_V = 0;

   typedef enum logic [3:0] {
      OP_UQ_ADD16   = 4'h0,
      OP_UQ_ADD8    = 4'h1,
      OP_UQ_SUB16   = 4'h2,
      OP_UQ_SUB8    = 4'h3,
      OP_UQ_ASX     = 4'h4,
      OP_UQ_SAX     = 4'h5,
      OP_PACK_BT    = 4'h6,
      OP_PACK_TB    = 4'h7,
      OP_SEXT_BACC  = 4'h8,
      OP_ZEXT_BACC  = 4'h9,
      OP_SEXT_HALF  = 4'ha,
      OP_ZEXT_HALF  = 4'hb
   } op_t;
endpackage

// ### core/usat_lane.sv
// One unsigned saturating add or subtract lane of parameterised width
`timescale 1ns/1ps
`default_nettype none
module usat_lane #(
   parameter int W = 8
) (
   input  wire logic [W-1:0] a,
   input  wire logic [W-1:0] b,
   input  wire logic         sub,
   output logic      [W-1:0] y
);
   logic [W:0] wide;

   always_comb begin
      if (sub) begin
         wide = {1'b0, a} - {1'b0, b};
         // Borrow out means the true result is below zero
         y    = wide[W] ? '0 : wide[W-1:0];
      end else begin
         wide = {1'b0, a} + {1'b0, b};
         // Carry out means the true result passed the lane maximum
         y    = wide[W] ? '1 : wide[W-1:0];
      end
   end
endmodule
`default_nettype wire

// ### testbench/rf_model.sv
// Register file side: records each committed write-back
`timescale 1ns/1ps
`default_nettype none
module rf_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        writeEnable,
   input  wire logic [3:0]  resultDest,
   input  wire logic [31:0] result,
   output int               writes,
   output int               badDest
);
   logic [31:0] regs [16];
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         writes  <= 0;
         badDest <= 0;
      end else if (writeEnable) begin
         regs[resultDest] <= result;
         writes <= writes + 1;
         if (resultDest == 4'hd || resultDest == 4'hf) begin
            badDest <= badDest + 1;
         end
      end
   end
endmodule
`default_nettype wire

// ### testbench/simd_pack_alu_sva.sv
// Port assertions for the saturating SIMD and pack datapath
`timescale 1ns/1ps
`default_nettype none
module simd_pack_alu_sva #(
   parameter int W = 32
) (
   input wire logic         clk,
   input wire logic         rst,
   input wire logic         issueValid,
   input wire logic [3:0]   opcode,
   input wire logic [3:0]   cond,
   input wire logic [3:0]   flagsIn,
   input wire logic [W-1:0] operandA,
   input wire logic [W-1:0] operandB,
   input wire logic [4:0]   shiftAmt,
   input wire logic [1:0]   rotSel,
   input wire logic [3:0]   destIdx,
   input wire logic [W-1:0] result,
   input wire logic [3:0]   resultDest,
   input wire logic         writeEnable,
   input wire logic         condFailed,
   input wire logic [3:0]   flagsOut
);
   default clocking @(posedge clk); endclocking
   default disable iff rst;
   a_flags_untouched: assert property (!$past(rst) |-> flagsOut == $past(flagsIn))
      else $error("flags output differs from flags input");
   a_issue_answers: assert property (issueValid && opcode <= 4'hb |=> writeEnable ^ condFailed)
      else $error("taken operation gave no single pulse");
   a_idle_silent: assert property (!(issueValid && opcode <= 4'hb) |=> !writeEnable && !condFailed)
      else $error("pulse without a taken operation");
   a_dest_echo: assert property (writeEnable |-> resultDest == $past(destIdx))
      else $error("destination index not echoed");
   a_result_hold: assert property (!writeEnable |-> $stable(result))
      else $error("result changed without a write");
   a_add16_low: assert property (issueValid && opcode == 4'h0 && cond[3:1] == 3'h7 |=>
      result[15:0] == ($past({1'b0, operandA[15:0]} + operandB[15:0]) > 17'hffff ? 16'hffff
      : $past(operandA[15:0] + operandB[15:0]))) else $error("halfword add lane wrong");
   a_sub8_low: assert property (issueValid && opcode == 4'h3 && cond[3:1] == 3'h7 |=>
      result[7:0] == ($past(operandA[7:0] < operandB[7:0]) ? 8'h00
      : $past(operandA[7:0] - operandB[7:0]))) else $error("byte subtract lane wrong");
   a_pack_plain: assert property (issueValid && opcode == 4'h6 && shiftAmt == 5'h00
      && cond[3:1] == 3'h7 |=> result == $past({operandB[31:16], operandA[15:0]}))
      else $error("unshifted pack wrong");
   a_pack_full: assert property (issueValid && opcode == 4'h7 && shiftAmt == 5'h00
      && cond[3:1] == 3'h7 |=> result == $past({operandA[31:16], {16{operandB[31]}}}))
      else $error("full-width pack shift wrong");
endmodule
bind simd_pack_alu simd_pack_alu_sva #(.W(W)) chk_u (.clk, .rst, .issueValid, .opcode, .cond,
   .flagsIn, .operandA, .operandB, .shiftAmt, .rotSel, .destIdx, .result, .resultDest,
   .writeEnable, .condFailed, .flagsOut);
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the saturating SIMD and pack datapath
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 0, rst = 1, issueValid = 0;
   logic [3:0] opcode = 0, cond = 0, flagsIn = 0, destIdx = 0, resultDest, flagsOut;
   logic [31:0] operandA = 0, operandB = 0, result, prev = 0;
   logic [4:0] shiftAmt = 0;
   logic [1:0] rotSel = 0;
   logic writeEnable, condFailed;
   int err_count = 0, check_count = 0, nWr = 0, cyc = 0, writes, badDest;
   simd_pack_alu dut_u (.clk, .rst, .issueValid, .opcode, .cond, .flagsIn, .operandA,
      .operandB, .shiftAmt, .rotSel, .destIdx, .result, .resultDest, .writeEnable,
      .condFailed, .flagsOut);
   rf_model rf_u (.clk, .rst, .writeEnable, .resultDest, .result, .writes, .badDest);
   initial begin
      forever #5 clk = ~clk;
   end
   function automatic int ls(int x, int y, bit s, int m);
      int t;
      t = s ? x - y : x + y;
      return t < 0 ? 0 : (t > m ? m : t);
   endfunction
   function automatic logic cp(logic [3:0] c, logic [3:0] f);
      logic n, z, k, v, b;
      {n, z, k, v} = f;
      case (c[3:1])
         3'h0: b = z;
         3'h1: b = k;
         3'h2: b = n;
         3'h3: b = v;
         3'h4: b = k && !z;
         3'h5: b = n == v;
         3'h6: b = !z && n == v;
         default: b = 1'b1;
      endcase
      return c[3:1] == 3'h7 ? 1'b1 : b ^ c[0];
   endfunction
   function automatic logic [31:0] ev(logic [3:0] op, logic [31:0] a, b, logic [4:0] sh,
                                      logic [1:0] r);
      logic [31:0] y, t, q;
      q = (b >> (8 * r)) | (b << (32 - 8 * r));
      y = 32'h0;
      case (op)
         4'h0, 4'h2: y = {16'(ls(a[31:16], b[31:16], op[1], 65535)),
                          16'(ls(a[15:0], b[15:0], op[1], 65535))};
         4'h1, 4'h3: for (int i = 0; i < 4; i++) y[8*i+:8] = 8'(ls(a[8*i+:8], b[8*i+:8], op[1], 255));
         4'h4: y = {16'(ls(a[31:16], b[15:0], 0, 65535)), 16'(ls(a[15:0], b[31:16], 1, 65535))};
         4'h5: y = {16'(ls(a[31:16], b[15:0], 1, 65535)), 16'(ls(a[15:0], b[31:16], 0, 65535))};
         4'h6: begin
            t = b << sh;
            y = {t[31:16], a[15:0]};
         end
         4'h7: begin
            t = $signed(b) >>> (sh == 5'h00 ? 32 : int'(sh));
            y = {a[31:16], t[15:0]};
         end
         4'h8: y = a + {{24{q[7]}}, q[7:0]};
         4'h9: y = a + {24'h0, q[7:0]};
         4'ha: y = {{16{q[15]}}, q[15:0]};
         4'hb: y = {16'h0, q[15:0]};
         default: y = 32'h0;
      endcase
      return y;
   endfunction
   task automatic chk(logic [31:0] g, logic [31:0] x);
      check_count++;
      if (g !== x) begin
         $display("BAD t=%0t got=%h exp=%h", $time, g, x);
         err_count++;
      end
   endtask
   task automatic run(logic [3:0] op, logic [31:0] a, b, logic [4:0] sh, logic [1:0] r,
                      logic [3:0] c, f);
      logic [3:0] d;
      logic ok, tk;
      d = 4'($urandom_range(0, 12));
      tk = op <= 4'hb;
      ok = tk && cp(c, f);
      issueValid <= 1'b1;
      opcode <= op;
      cond <= c;
      flagsIn <= f;
      operandA <= a;
      operandB <= b;
      shiftAmt <= sh;
      rotSel <= r;
      destIdx <= d;
      @(posedge clk);
      issueValid <= 1'b0;
      #1;
      if (ok) prev = ev(op, a, b, sh, r);
      chk(result, prev);
      chk(32'(writeEnable), 32'(ok));
      chk(32'(condFailed), 32'(tk && !ok));
      chk(32'(flagsOut), 32'(f));
      if (ok) chk(32'(resultDest), 32'(d));
      if (ok) nWr++;
      @(posedge clk);
      #1;
      if (ok) chk(rf_u.regs[d], prev);
      @(posedge clk);
   endtask
   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc > 5000) begin
         err_count++;
         end_sim();
      end
   end
   initial begin
      void'($urandom(76544));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      run(4'h0, 32'hffff0001, 32'h00010001, 5'h00, 2'h0, 4'he, 4'hf);
      run(4'h1, 32'h80ff7f01, 32'h80017f01, 5'h00, 2'h0, 4'hf, 4'h0);
      run(4'h2, 32'h00010005, 32'h00020003, 5'h00, 2'h0, 4'he, 4'h0);
      run(4'h3, 32'h01ff0510, 32'h02010410, 5'h00, 2'h0, 4'he, 4'h0);
      run(4'h4, 32'hfff00010, 32'h00200020, 5'h00, 2'h0, 4'he, 4'h0);
      run(4'h5, 32'h0010fff0, 32'h00200020, 5'h00, 2'h0, 4'he, 4'h0);
      run(4'h6, 32'h1234abcd, 32'h00015678, 5'h10, 2'h0, 4'he, 4'h0);
      run(4'h6, 32'h1234abcd, 32'h9abc5678, 5'h00, 2'h0, 4'he, 4'h0);
      run(4'h7, 32'h1234abcd, 32'h80005678, 5'h00, 2'h0, 4'he, 4'h0);
      run(4'h7, 32'h1234abcd, 32'h80005678, 5'h01, 2'h0, 4'he, 4'h0);
      run(4'h8, 32'h00000010, 32'h000080ff, 5'h00, 2'h1, 4'he, 4'h0);
      run(4'h9, 32'h00000010, 32'h000000ff, 5'h00, 2'h0, 4'he, 4'h0);
      run(4'ha, 32'h0, 32'h8001ffff, 5'h00, 2'h2, 4'he, 4'h0);
      run(4'hb, 32'h0, 32'h8001ffff, 5'h00, 2'h3, 4'he, 4'h0);
      run(4'h0, 32'h00010001, 32'h00010001, 5'h00, 2'h0, 4'h0, 4'h0);
      run(4'hc, 32'h00010001, 32'h00010001, 5'h00, 2'h0, 4'he, 4'h0);
      $display("test corner done");
      for (int i = 0; i < 400; i++) begin
         run(4'($urandom_range(0, 13)), $urandom, $urandom, 5'($urandom), 2'($urandom),
             4'($urandom), 4'($urandom));
      end
      chk(32'(writes), 32'(nWr));
      chk(32'(badDest), 32'h0);
      $display("test random done");
      end_sim();
   end
endmodule
`default_nettype wire
